// File: logic/mib_pkg.sv
// Constants and carrier types of the port statistics counter bank.
// Assumes a single 50 MHz clock domain shared with the switch core.
package mib_pkg;
    localparam int NPORT = 3;
    localparam int NOFS = 32;
    localparam int FIRST_OFS = 12;
    localparam int NDROP = 6;
    localparam int CNT_W = 30;
    localparam int DROP_W = 16;
    localparam int LEN_W = 11;
    // Per-port counter offsets within one port's span
    localparam int OFS_RX_GROUP = 12;
    localparam int OFS_RX_SINGLE = 13;
    localparam int OFS_RX_64 = 14;
    localparam int OFS_RX_65_127 = 15;
    localparam int OFS_RX_128_255 = 16;
    localparam int OFS_RX_256_511 = 17;
    localparam int OFS_RX_512_1023 = 18;
    localparam int OFS_RX_1024_MAX = 19;
    localparam int OFS_TX_LOW_OCT = 20;
    localparam int OFS_TX_HIGH_OCT = 21;
    localparam int OFS_TX_LATE_COLL = 22;
    localparam int OFS_TX_FLOW_STOP = 23;
    localparam int OFS_TX_ALL_DEST = 24;
    localparam int OFS_TX_GROUP = 25;
    localparam int OFS_TX_SINGLE = 26;
    localparam int OFS_TX_WAIT = 27;
    localparam int OFS_TX_ALL_COLL = 28;
    localparam int OFS_TX_ABANDON = 29;
    localparam int OFS_TX_ONE_COLL = 30;
    localparam int OFS_TX_MULTI_COLL = 31;
    // Port bases, drop space, register map
    localparam logic [7:0] PORT_SPAN = 8'h20;
    localparam logic [8:0] DROP_BASE = 9'h100;
    localparam logic [7:0] REG_TABLE_SEL = 8'h79;
    localparam logic [7:0] REG_TRIGGER = 8'h7A;
    localparam logic [7:0] REG_DATA3 = 8'h80;
    localparam logic [7:0] REG_DATA2 = 8'h81;
    localparam logic [7:0] REG_DATA1 = 8'h82;
    localparam logic [7:0] REG_DATA0 = 8'h83;
    localparam logic [7:0] REG_FRAME_CFG = 8'h84;
    localparam logic [7:0] CMD_PORT_CNT = 8'h1C;
    localparam logic [7:0] CMD_DROP_CNT = 8'h1D;
    localparam logic [6:0] CMD_MIB_SPACE = 7'h0E;
    localparam int OVF_BIT = 31;
    localparam int VALID_BIT = 30;
    localparam int CFG_BIG_BIT = 0;
    // Frame length bin edges in octets
    localparam logic [10:0] LEN_64 = 11'h040;
    localparam logic [10:0] LEN_127 = 11'h07F;
    localparam logic [10:0] LEN_255 = 11'h0FF;
    localparam logic [10:0] LEN_511 = 11'h1FF;
    localparam logic [10:0] LEN_1023 = 11'h3FF;
    localparam logic [10:0] LEN_MAX_STD = 11'h5F2;
    localparam logic [10:0] LEN_MAX_BIG = 11'h600;
    // Reset values
    localparam logic [CNT_W-1:0] CNT_RST = 30'h0;
    localparam logic [DROP_W-1:0] DROP_RST = 16'h0;
    localparam logic [31:0] DATA_RST = 32'h0;
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic rx_done;
        logic [LEN_W-1:0] rx_len;
        logic rx_good;
        logic rx_group;
        logic rx_all_dest;
        logic rx_ctrl;
        logic tx_done;
        logic [LEN_W-1:0] tx_len;
        logic tx_good;
        logic tx_high;
        logic tx_flow_stop;
        logic tx_all_dest;
        logic tx_group;
        logic tx_deferred;
        logic [4:0] tx_coll_n;
        logic tx_coll;
        logic tx_late_coll;
        logic tx_abandon;
        logic half_duplex;
        logic tx_drop;
        logic rx_drop;
    } port_ev_t;
endpackage

// File: logic/port_statistics_counters.sv
// Per-port statistics counter bank with indirect read access.
// Event strobes come from the MAC logic on mclk; register port is
// a plain one-cycle strobe bus with read data one cycle later.
// Functional notes
// - Count good received group frames, excluding control, errored, all-dest.
// - Count good received single-destination frames at offset 0xD.
// - Count every received 64-octet frame, good or bad, at 0xE.
// - Bin all received frames by length into 0xF through 0x12.
// - Count 1024-to-max octet frames at 0x13; max follows frame config.
// - Sum good transmitted octets per priority, pause frames included.
// - Count collisions seen after 512 bit times at 0x16.
// - Count transmitted pause frames at 0x17.
// - Count good transmitted all-dest, group and single frames separately.
// - Count frames whose first attempt was deferred by a busy medium.
// - Count all transmit collisions at 0x1C, half duplex only.
// - Count frames abandoned after excessive collisions at 0x1D.
// - Count sent frames with exactly one, and more than one, collision.
// - Drop counters are 16 bits, reset zero, upper bits read zero.
// - Transmit drop counts for ports 1 to 3 at 0x100 to 0x102.
// - Receive drop counts for ports 1 to 3 at 0x103 to 0x105.
// - Trigger offset is port base plus counter offset.
// - After trigger, overflow sits in bit 31 of 0x80, valid and count bits 29-24 below it, rest 0x81-0x83.
// - Port bases are 0x00, 0x20 and 0x40, 32 offsets each.
// - Counter word: overflow bit 31, valid bit 30, count 29 to 0.
// - Per-port counters clear when read.
// - Drop counters never clear on read, carry no flags.
module port_statistics_counters
    import mib_pkg::*;
#(
    parameter int CW = CNT_W
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire reg_req_t req,
    output logic [7:0] rdata,
    input wire port_ev_t [NPORT-1:0] ev
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic [7:0] sel_r;
    logic [7:0] trig_r;
    logic [7:0] cfg_r;
    logic [31:0] data_r;
    logic [7:0] rdata_r;
    logic [31:0] data_nxt;
    logic [7:0] rdata_nxt;

    wire sel_we = req.wr && req.addr == REG_TABLE_SEL;
    wire cfg_we = req.wr && req.addr == REG_FRAME_CFG;
    wire mib_sel = sel_r[7:1] == CMD_MIB_SPACE;
    wire trig_we = req.wr && req.addr == REG_TRIGGER && mib_sel;
    wire [8:0] ind_addr = {sel_r[0], req.wdata};
    wire drop_sp = ind_addr[8];
    wire [1:0] hit_port = ind_addr[6:5];
    wire [4:0] hit_ofs = ind_addr[4:0];
    wire port_ok = !drop_sp && ind_addr[7] == 1'b0 && hit_port != 2'd3;
    wire [8:0] drop_idx = ind_addr - DROP_BASE;
    wire drop_ok = drop_sp && drop_idx < 9'(NDROP);
    wire [10:0] max_len = cfg_r[CFG_BIG_BIT] ? LEN_MAX_BIG : LEN_MAX_STD;

    logic [CW-1:0] cnt_w [NPORT*NOFS];
    logic ovf_w [NPORT*NOFS];
    logic [DROP_W-1:0] drop_w [NDROP];

    function automatic logic in_rng(logic [10:0] l, logic [10:0] lo,
                                    logic [10:0] hi);
        in_rng = l >= lo && l <= hi;
    endfunction

    // Amount that one event cycle adds to counter k of a port
    function automatic logic [LEN_W-1:0] inc_of(int k, port_ev_t e,
                                                 logic [10:0] mx);
        logic rg;
        logic tg;
        rg = e.rx_done && e.rx_good;
        tg = e.tx_done && e.tx_good;
        inc_of = '0;
        unique case (k)
            OFS_RX_GROUP: inc_of = LEN_W'(rg && e.rx_group
                && !e.rx_all_dest && !e.rx_ctrl);
            OFS_RX_SINGLE: inc_of = LEN_W'(rg && !e.rx_group
                && !e.rx_all_dest);
            OFS_RX_64: inc_of = LEN_W'(e.rx_done
                && e.rx_len == LEN_64);
            OFS_RX_65_127: inc_of = LEN_W'(e.rx_done
                && in_rng(e.rx_len, LEN_64 + 11'h001, LEN_127));
            OFS_RX_128_255: inc_of = LEN_W'(e.rx_done
                && in_rng(e.rx_len, LEN_127 + 11'h001, LEN_255));
            OFS_RX_256_511: inc_of = LEN_W'(e.rx_done
                && in_rng(e.rx_len, LEN_255 + 11'h001, LEN_511));
            OFS_RX_512_1023: inc_of = LEN_W'(e.rx_done
                && in_rng(e.rx_len, LEN_511 + 11'h001, LEN_1023));
            OFS_RX_1024_MAX: inc_of = LEN_W'(e.rx_done
                && in_rng(e.rx_len, LEN_1023 + 11'h001, mx));
            OFS_TX_LOW_OCT: inc_of = (tg && !e.tx_high)
                ? e.tx_len : '0;
            OFS_TX_HIGH_OCT: inc_of = (tg && e.tx_high)
                ? e.tx_len : '0;
            OFS_TX_LATE_COLL: inc_of = LEN_W'(e.tx_late_coll);
            OFS_TX_FLOW_STOP: inc_of = LEN_W'(e.tx_done
                && e.tx_flow_stop);
            OFS_TX_ALL_DEST: inc_of = LEN_W'(tg && e.tx_all_dest);
            OFS_TX_GROUP: inc_of = LEN_W'(tg && e.tx_group
                && !e.tx_all_dest);
            OFS_TX_SINGLE: inc_of = LEN_W'(tg && !e.tx_group
                && !e.tx_all_dest);
            OFS_TX_WAIT: inc_of = LEN_W'(e.tx_done
                && e.tx_deferred);
            OFS_TX_ALL_COLL: inc_of = LEN_W'(e.tx_coll
                && e.half_duplex);
            OFS_TX_ABANDON: inc_of = LEN_W'(e.tx_abandon);
            OFS_TX_ONE_COLL: inc_of = LEN_W'(tg
                && e.tx_coll_n == 5'h01);
            OFS_TX_MULTI_COLL: inc_of = LEN_W'(tg
                && e.tx_coll_n > 5'h01);
            default: inc_of = '0;
        endcase
    endfunction

    // Counter array: unimplemented receive offsets stay at zero
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        for (genvar k = 0; k < NOFS; k++)
        begin : g_cnt
            if (k < FIRST_OFS)
            begin : g_none
                assign cnt_w[p*NOFS+k] = CW'(CNT_RST);
                assign ovf_w[p*NOFS+k] = 1'b0;
            end
            else
            begin : g_live
                logic [CW-1:0] c_r;
                logic o_r;
                wire clr = trig_we && port_ok && hit_port == 2'(p)
                    && hit_ofs == 5'(k);
                wire [LEN_W-1:0] inc = inc_of(k, ev[p], max_len);
                wire [CW:0] sum = {1'b0, c_r} + (CW+1)'(inc);
                // A clear that meets an event keeps the event
                wire [CW-1:0] c_nxt = clr ? CW'(inc) : sum[CW-1:0];
                wire o_nxt = clr ? 1'b0 : (o_r | sum[CW]);
                always_ff @(posedge mclk or posedge rst)
                begin
                    if (rst)
                    begin
                        c_r <= CW'(CNT_RST);
                        o_r <= 1'b0;
                    end
                    else
                    begin
                        c_r <= c_nxt;
                        o_r <= o_nxt;
                    end
                end
                assign cnt_w[p*NOFS+k] = c_r;
                assign ovf_w[p*NOFS+k] = o_r;
            end
        end
    end

    // Drop counters: index 0-2 transmit, 3-5 receive, no read clear
    for (genvar d = 0; d < NDROP; d++)
    begin : g_drop
        logic [DROP_W-1:0] d_r;
        wire hit = d < NPORT ? ev[d % NPORT].tx_drop
            : ev[d % NPORT].rx_drop;
        wire [DROP_W-1:0] d_nxt = d_r + DROP_W'(hit);
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
                d_r <= DROP_RST;
            else
                d_r <= d_nxt;
        end
        assign drop_w[d] = d_r;
    end

    // Snapshot selected on the trigger write
    wire [6:0] pidx = 7'({hit_port, hit_ofs});
    wire [31:0] port_word = {ovf_w[pidx], 1'b1, CNT_W'(cnt_w[pidx])};
    wire [2:0] didx = drop_idx[2:0];
    wire [31:0] drop_word = {16'h0000, drop_w[didx]};
    wire [31:0] snap = port_ok ? port_word
        : (drop_ok ? drop_word : DATA_RST);
    assign data_nxt = trig_we ? snap : data_r;

    // Register read mux; unmapped addresses answer zero
    wire [7:0] rd_mux =
        req.addr == REG_TABLE_SEL ? sel_r :
        req.addr == REG_TRIGGER ? trig_r :
        req.addr == REG_DATA3 ? data_r[31:24] :
        req.addr == REG_DATA2 ? data_r[23:16] :
        req.addr == REG_DATA1 ? data_r[15:8] :
        req.addr == REG_DATA0 ? data_r[7:0] :
        req.addr == REG_FRAME_CFG ? cfg_r : 8'h00;
    assign rdata_nxt = req.rd ? rd_mux : 8'h00;
    assign rdata = rdata_r;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sel_r <= SEL_RST;
            trig_r <= SEL_RST;
            cfg_r <= CFG_RST;
            data_r <= DATA_RST;
            rdata_r <= 8'h00;
        end
        else
        begin
            if (sel_we)
                sel_r <= req.wdata;
            if (trig_we)
                trig_r <= req.wdata;
            if (cfg_we)
                cfg_r <= req.wdata;
            data_r <= data_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    a_data_hi_read: assert property (
        req.rd && req.addr == REG_DATA3 |=> rdata == $past(data_r[31:24]))
        else $error("Byte of data register 0x80 not returned");

    a_trig_valid_flag: assert property (
        trig_we && port_ok
        |=> data_r[VALID_BIT] && data_r[29:0] == $past(cnt_w[pidx]))
        else $error("Counter snapshot missing valid flag or value");

    a_clear_on_read: assert property (
        trig_we && sel_r == CMD_PORT_CNT && req.wdata == 8'h0E
        && !ev[0].rx_done |=> cnt_w[OFS_RX_64] == CNT_RST)
        else $error("Counter not cleared by its read");

    a_rx64_count: assert property (
        ev[0].rx_done && ev[0].rx_len == LEN_64 && !trig_we
        |=> cnt_w[OFS_RX_64] == CW'($past(cnt_w[OFS_RX_64]) + 1'b1))
        else $error("64-octet frame not counted");

    a_tx_low_octets: assert property (
        ev[2].tx_done && ev[2].tx_good && !ev[2].tx_high && !trig_we
        |=> cnt_w[2*NOFS+OFS_TX_LOW_OCT]
            == CW'($past(cnt_w[2*NOFS+OFS_TX_LOW_OCT])
            + $past(ev[2].tx_len)))
        else $error("Low priority octets not accumulated");

    a_max_len_bin: assert property (
        ev[0].rx_done && ev[0].rx_len > LEN_MAX_STD
        && !cfg_r[CFG_BIG_BIT] && !trig_we
        |=> $stable(cnt_w[OFS_RX_1024_MAX]))
        else $error("Frame above maximum counted in top bin");

    a_port2_base: assert property (
        trig_we && sel_r == CMD_PORT_CNT && req.wdata == 8'h2E
        |=> data_r[29:0] == $past(cnt_w[NOFS+OFS_RX_64]))
        else $error("Port 2 64-octet counter not selected");

    a_drop_space: assert property (
        trig_we && sel_r == CMD_DROP_CNT && req.wdata == 8'h03
        |=> data_r == {16'h0000, $past(drop_w[3])})
        else $error("Drop counter at 0x103 not returned");

    a_drop_keeps: assert property (
        trig_we && drop_ok && didx == 3'h0 && !ev[0].tx_drop
        |=> $stable(drop_w[0]))
        else $error("Drop counter changed on read");

    a_drop_format: assert property (
        trig_we && drop_ok |=> data_r[31:16] == 16'h0000
        && data_r[15:0] == $past(drop_w[didx]))
        else $error("Drop counter upper bits not zero");

    a_rx_group_count: assert property (
        ev[1].rx_done && ev[1].rx_good && ev[1].rx_group
        && !ev[1].rx_all_dest && !ev[1].rx_ctrl && !trig_we
        |=> cnt_w[NOFS+OFS_RX_GROUP]
            == CW'($past(cnt_w[NOFS+OFS_RX_GROUP]) + 1'b1))
        else $error("Good group frame not counted");

    a_rx_group_skip: assert property (
        ev[1].rx_done && (ev[1].rx_ctrl || ev[1].rx_all_dest
        || !ev[1].rx_good) && !trig_we
        |=> $stable(cnt_w[NOFS+OFS_RX_GROUP]))
        else $error("Excluded frame counted as group frame");

    a_rx_single_count: assert property (
        ev[0].rx_done && ev[0].rx_good && !ev[0].rx_group
        && !ev[0].rx_all_dest && !trig_we
        |=> cnt_w[OFS_RX_SINGLE]
            == CW'($past(cnt_w[OFS_RX_SINGLE]) + 1'b1))
        else $error("Good single-destination frame not counted");

    a_rx_bin_128: assert property (
        ev[0].rx_done && ev[0].rx_len > LEN_127 && ev[0].rx_len <= LEN_255
        && !trig_we
        |=> cnt_w[OFS_RX_128_255]
            == CW'($past(cnt_w[OFS_RX_128_255]) + 1'b1))
        else $error("Frame of 128 to 255 octets not binned");

    a_top_bin_big: assert property (
        ev[0].rx_done && ev[0].rx_len == LEN_MAX_BIG
        && cfg_r[CFG_BIG_BIT] && !trig_we
        |=> cnt_w[OFS_RX_1024_MAX]
            == CW'($past(cnt_w[OFS_RX_1024_MAX]) + 1'b1))
        else $error("Frame at larger maximum not counted in top bin");

    a_tx_high_octets: assert property (
        ev[2].tx_done && ev[2].tx_good && ev[2].tx_high && !trig_we
        |=> cnt_w[2*NOFS+OFS_TX_HIGH_OCT]
            == CW'($past(cnt_w[2*NOFS+OFS_TX_HIGH_OCT])
            + $past(ev[2].tx_len)))
        else $error("High priority octets not accumulated");

    a_late_coll: assert property (
        ev[2].tx_late_coll && !trig_we
        |=> cnt_w[2*NOFS+OFS_TX_LATE_COLL]
            == CW'($past(cnt_w[2*NOFS+OFS_TX_LATE_COLL]) + 1'b1))
        else $error("Late collision not counted");

    a_flow_stop_count: assert property (
        ev[2].tx_done && ev[2].tx_flow_stop && !trig_we
        |=> cnt_w[2*NOFS+OFS_TX_FLOW_STOP]
            == CW'($past(cnt_w[2*NOFS+OFS_TX_FLOW_STOP]) + 1'b1))
        else $error("Transmitted pause frame not counted");

    a_tx_all_dest: assert property (
        ev[2].tx_done && ev[2].tx_good && ev[2].tx_all_dest && !trig_we
        |=> cnt_w[2*NOFS+OFS_TX_ALL_DEST]
            == CW'($past(cnt_w[2*NOFS+OFS_TX_ALL_DEST]) + 1'b1))
        else $error("Good all-destination frame not counted");

    a_tx_wait_count: assert property (
        ev[2].tx_done && ev[2].tx_deferred && !trig_we
        |=> cnt_w[2*NOFS+OFS_TX_WAIT]
            == CW'($past(cnt_w[2*NOFS+OFS_TX_WAIT]) + 1'b1))
        else $error("Deferred frame not counted");

    a_coll_half_dup: assert property (
        ev[2].tx_coll && ev[2].half_duplex && !trig_we
        |=> cnt_w[2*NOFS+OFS_TX_ALL_COLL]
            == CW'($past(cnt_w[2*NOFS+OFS_TX_ALL_COLL]) + 1'b1))
        else $error("Half duplex collision not counted");

    a_coll_full_dup: assert property (
        ev[2].tx_coll && !ev[2].half_duplex && !trig_we
        |=> $stable(cnt_w[2*NOFS+OFS_TX_ALL_COLL]))
        else $error("Full duplex collision counted");

    a_abandon_count: assert property (
        ev[2].tx_abandon && !trig_we
        |=> cnt_w[2*NOFS+OFS_TX_ABANDON]
            == CW'($past(cnt_w[2*NOFS+OFS_TX_ABANDON]) + 1'b1))
        else $error("Abandoned frame not counted");

    a_multi_coll: assert property (
        ev[2].tx_done && ev[2].tx_good && ev[2].tx_coll_n > 5'h01
        && !trig_we
        |=> cnt_w[2*NOFS+OFS_TX_MULTI_COLL]
            == CW'($past(cnt_w[2*NOFS+OFS_TX_MULTI_COLL]) + 1'b1))
        else $error("Frame with several collisions not counted");

    a_drop_tx_count: assert property (
        ev[2].tx_drop |=> drop_w[2] == $past(drop_w[2]) + 16'h0001)
        else $error("Transmit drop of port 3 not counted");

    a_port_range: assert property (
        trig_we && sel_r == CMD_PORT_CNT && req.wdata >= 8'h60
        |=> data_r == DATA_RST)
        else $error("Offset beyond port spans returned data");

    a_rdata_idle: assert property (
        !req.rd |=> rdata == 8'h00)
        else $error("Read data present without a read strobe");

    c_port_read: cover property (
        trig_we && port_ok ##1 req.rd && req.addr == REG_DATA3);
    c_overflow_seen: cover property (
        trig_we && port_ok && ovf_w[pidx]);
    c_drop_read: cover property (
        trig_we && drop_ok ##1 req.rd && req.addr == REG_DATA1);
    c_event_on_clear: cover property (
        trig_we && port_ok && hit_ofs == 5'(OFS_RX_64) && ev[0].rx_done);
endmodule

// File: tb/tb_port_statistics_counters.sv
// Self-checking bench for the port statistics counter bank.
// Drives the register strobe bus and the MAC event pulses itself;
// the counter width is cut to 8 bits so overflow comes quickly.
module tb_port_statistics_counters
    import mib_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TW = 8;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    reg_req_t req = '0;
    logic [7:0] rdata;
    port_ev_t [NPORT-1:0] ev = '0;
    int failures = 0;
    int checks = 0;

    always #10 mclk = ~mclk;

    port_statistics_counters #(.CW(TW)) i_port_statistics_counters (
        .mclk(mclk),
        .rst(rst),
        .req(req),
        .rdata(rdata),
        .ev(ev)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic get(input logic [7:0] cmd, input logic [7:0] ofs,
                       output logic [31:0] w);
        logic [7:0] b;
        int n;
        wr(REG_TABLE_SEL, cmd);
        wr(REG_TRIGGER, ofs);
        n = 0;
        rd(REG_DATA3, b);
        while (cmd == CMD_PORT_CNT && b[6] !== 1'b1 && n < 4)
        begin
            n++;
            rd(REG_DATA3, b);
        end
        if (cmd == CMD_PORT_CNT && b[6] !== 1'b1)
        begin
            failures++;
            test_done();
        end
        w[31:24] = b;
        rd(REG_DATA2, b);
        w[23:16] = b;
        rd(REG_DATA1, b);
        w[15:8] = b;
        rd(REG_DATA0, b);
        w[7:0] = b;
    endtask

    task automatic pc(input int p, input logic [7:0] o, input int n);
        logic [31:0] w;
        get(CMD_PORT_CNT, 8'(p) * PORT_SPAN + o, w);
        chk(w, 32'h4000_0000 + 32'(n));
    endtask

    task automatic pulse(input int p, input port_ev_t e, input int n);
        @(posedge mclk);
        ev[p] <= e;
        repeat (n) @(posedge mclk);
        ev[p] <= '0;
    endtask

    // Flags are good, group, all-dest, control
    task automatic rxf(input int p, input logic [10:0] len,
                       input logic [3:0] f, input int n);
        port_ev_t e;
        e = '0;
        e.rx_done = 1'b1;
        e.rx_len = len;
        {e.rx_good, e.rx_group, e.rx_all_dest, e.rx_ctrl} = f;
        pulse(p, e, n);
    endtask

    // Flags are good, high, pause, all-dest, group, deferred
    task automatic txf(input logic [10:0] len, input logic [5:0] f,
                       input logic [4:0] cn);
        port_ev_t e;
        e = '0;
        e.tx_done = 1'b1;
        e.tx_len = len;
        e.tx_coll_n = cn;
        {e.tx_good, e.tx_high, e.tx_flow_stop, e.tx_all_dest, e.tx_group,
         e.tx_deferred} = f;
        pulse(2, e, 1);
    endtask

    task automatic t_reset();
        logic [31:0] w;
        logic [7:0] b;
        pc(0, 8'h0E, 0);
        get(CMD_DROP_CNT, 8'h05, w);
        chk(w, 32'h0000_0000);
        rd(8'h10, b);
        chk({24'h0, b}, 32'h0000_0000);
        wr(REG_TABLE_SEL, CMD_PORT_CNT);
        wr(REG_TRIGGER, 8'h60);
        rd(REG_DATA3, b);
        chk({24'h0, b}, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_bins();
        logic [10:0] lens [12] = '{11'd64, 11'd65, 11'd127, 11'd128,
            11'd255, 11'd256, 11'd511, 11'd512, 11'd1023, 11'd1024,
            11'd1522, 11'd1523};
        int exp [6] = '{1, 2, 2, 2, 2, 2};
        for (int i = 0; i < 12; i++)
            rxf(0, lens[i], {i < 6, 3'b000}, 1);
        for (int i = 0; i < 6; i++)
            pc(0, 8'h0E + 8'(i), exp[i]);
        pc(0, 8'h0D, 6);
        pc(0, 8'h0E, 0);
        wr(REG_FRAME_CFG, 8'h01);
        rxf(0, 11'd1536, 4'b0000, 1);
        rxf(0, 11'd1537, 4'b0000, 1);
        pc(0, 8'h13, 1);
        wr(REG_FRAME_CFG, 8'h00);
        $display("test length bins done");
    endtask

    task automatic t_rx_class();
        logic [3:0] fl [6] = '{4'b1100, 4'b1110, 4'b1101, 4'b0100,
            4'b1000, 4'b1010};
        for (int i = 0; i < 6; i++)
            rxf(1, 11'd64, fl[i], 1);
        pc(1, 8'h0C, 1);
        pc(1, 8'h0D, 1);
        pc(1, 8'h0E, 6);
        $display("test receive classes done");
    endtask

    task automatic t_tx();
        port_ev_t e;
        int exp [12] = '{164, 200, 2, 1, 1, 1, 1, 1, 3, 1, 1, 1};
        txf(11'd100, 6'b100000, 5'd1);
        txf(11'd200, 6'b110100, 5'd2);
        txf(11'd64, 6'b101011, 5'd0);
        txf(11'd300, 6'b000000, 5'd1);
        e = '0;
        e.tx_late_coll = 1'b1;
        pulse(2, e, 2);
        e = '0;
        e.tx_abandon = 1'b1;
        pulse(2, e, 1);
        e = '0;
        e.tx_coll = 1'b1;
        e.half_duplex = 1'b1;
        pulse(2, e, 3);
        e.half_duplex = 1'b0;
        pulse(2, e, 1);
        for (int i = 0; i < 12; i++)
            pc(2, 8'h14 + 8'(i), exp[i]);
        $display("test transmit counters done");
    endtask

    task automatic t_drop();
        port_ev_t e;
        logic [31:0] w;
        int exp [6] = '{0, 0, 1, 2, 0, 0};
        e = '0;
        e.rx_drop = 1'b1;
        pulse(0, e, 2);
        e = '0;
        e.tx_drop = 1'b1;
        pulse(2, e, 1);
        repeat (2)
            for (int i = 0; i < 6; i++)
            begin
                get(CMD_DROP_CNT, 8'(i), w);
                chk(w, 32'(exp[i]));
            end
        $display("test drop counters done");
    endtask

    task automatic t_overflow();
        logic [31:0] w;
        rxf(2, 11'd64, 4'b1000, 257);
        get(CMD_PORT_CNT, 8'h4E, w);
        chk(w, 32'hC000_0001);
        pc(2, 8'h4E - 8'h40, 0);
        rxf(0, 11'd64, 4'b0000, 3);
        wr(REG_TABLE_SEL, 8'h04);
        wr(REG_TRIGGER, 8'h0E);
        pc(0, 8'h0E, 3);
        $display("test overflow done");
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_bins();
        t_rx_class();
        t_tx();
        t_drop();
        t_overflow();
        test_done();
    end
endmodule
